// File: pkg/dprc_map.vh
/*
 * register offsets, field positions, reset values and timing counts
 * for the regulator and ramp block.
 * assumes a 100 MHz control clock and a plain word-addressed register port.
 */
`ifndef DPRC_MAP_VH
`define DPRC_MAP_VH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define DPRC_CLK_PERIOD_NS 10
`define DPRC_TICK_US       1000
`define DPRC_RES0_US       10000
`define DPRC_RES1_US       100000
`define DPRC_RES2_US       1000000
`define DPRC_ITIME_UNIT_US 100000
`define DPRC_DTIME_UNIT_US 100

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define DPRC_CTRL_OFS     8'h00
`define DPRC_FFGAIN_OFS   8'h04
`define DPRC_KP_OFS       8'h08
`define DPRC_ITIME_OFS    8'h0c
`define DPRC_DTIME_OFS    8'h10
`define DPRC_LIMH_OFS     8'h14
`define DPRC_LIML_OFS     8'h18
`define DPRC_OSCALE_OFS   8'h1c
`define DPRC_KP2_OFS      8'h20
`define DPRC_PSCALE_OFS   8'h24
`define DPRC_CHGOVR_OFS   8'h28
`define DPRC_MAXF_OFS     8'h2c
`define DPRC_TMAP_OFS     8'h30
`define DPRC_STFREQ_OFS   8'h34
`define DPRC_STPID_OFS    8'h38
`define DPRC_PAIR2_OFS    8'h3c
`define DPRC_STEP_OFS     8'h40

// ----------------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------------
`define DPRC_CTRL_EN      0
`define DPRC_CTRL_FB_LO   1
`define DPRC_CTRL_NEG     3
`define DPRC_CTRL_AUX     4
`define DPRC_CTRL_RREF    5
`define DPRC_CTRL_RES_LO  6
`define DPRC_FUNC_NONE    3'h7

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define DPRC_CTRL_RST     8'h40
`define DPRC_FFGAIN_RST   16'h0000
`define DPRC_KP_RST       16'h000a
`define DPRC_ITIME_RST    16'h0064
`define DPRC_DTIME_RST    16'h0000
`define DPRC_LIMH_RST     16'h1770
`define DPRC_LIML_RST     16'h0000
`define DPRC_SCALE_RST    16'h03e8
`define DPRC_CHGOVR_RST   16'h0000
`define DPRC_MAXF_RST     16'h1770
`define DPRC_TMAP_RST     18'h3ffff
`define DPRC_TIME_RST     16'h0032
`define DPRC_FULL_PCT     10000
`define DPRC_GAIN_ONE     1000

`endif

// File: src/dprc_top.v
/*
 * frequency reference processing: closed-loop regulator feeding an
 * accel/decel ramp generator, with a plain register port.
 * assumes analog inputs already digitised to 0.01 % of full scale,
 * frequencies in 0.01 Hz, terminal pins asynchronous to i_mclk.
 */
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "dprc_map.vh"

// Summary of operation
// - bypass terminal on: run from manual command; off: back to regulation
// - feedback from current loop, voltage one or voltage two; current default
// - feed-forward adds reference times gain percent; 0.0 % disables it
// - regulator output is added to the target frequency before the ramp
// - proportional output equals gain times error, default gain 1.0 %
// - integral reaches 100 % for 100 % error in integral time, default 10 s
// - derivative acts on error change weighted by time; zero disables it
// - closed-loop output clamped to upper limit, default 60.00 Hz
// - closed-loop output clamped to lower limit, default 0.00 Hz
// - inversion setting negates regulator output, default not inverted
// - regulator output multiplied by scale percent, default 100.0 %
// - second proportional gain used while its terminal selects it
// - common scale multiplies both proportional gains, default 100.0 %
// - bypass terminal active forces regulator output to zero
// - integral clear terminal resets the accumulator to zero
// - ramp rate pair switches where output crosses change-over frequency
// - assigned multi-step ramp terminals take priority over change-over
// - ramp reference: 0 zero to max frequency, 1 present to target
// - time resolution: 0 is 0.01 s, 1 is 0.1 s default, 2 is 1 s
// - reference source selector, default no auxiliary reference
module dprc_top #(
  parameter TICK_CYCLES = `DPRC_TICK_US * 1000 / `DPRC_CLK_PERIOD_NS
) (
  input  wire        i_mclk,
  input  wire        i_rstn,
  input  wire [7:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rdata,
  input  wire [15:0] i_setpoint,
  input  wire [15:0] i_aux_ref,
  input  wire [15:0] i_fb_current,
  input  wire [15:0] i_voltage_feedback_one,
  input  wire [15:0] i_voltage_feedback_two,
  input  wire [15:0] i_target_freq,
  input  wire [5:0]  i_programmable_terminals,
  output reg  [15:0] o_freq_cmd,
  output reg  [15:0] o_pid_out,
  output reg         o_closed_loop
);

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  reg  [7:0]  ctrl_reg;
  reg  [15:0] ffgain_reg;
  reg  [15:0] kp_reg;
  reg  [15:0] itime_reg;
  reg  [15:0] dtime_reg;
  reg  [15:0] limh_reg;
  reg  [15:0] liml_reg;
  reg  [15:0] oscale_reg;
  reg  [15:0] kp2_reg;
  reg  [15:0] pscale_reg;
  reg  [15:0] chgovr_reg;
  reg  [15:0] maxf_reg;
  reg  [17:0] tmap_reg;
  reg  [31:0] pair2_reg;
  reg  [31:0] step_mem [0:7];
  reg  [31:0] rdata_next;
  integer     k;

  wire [1:0] fb_sel   = ctrl_reg[`DPRC_CTRL_FB_LO+1:`DPRC_CTRL_FB_LO];
  wire [1:0] res_sel  = ctrl_reg[`DPRC_CTRL_RES_LO+1:`DPRC_CTRL_RES_LO];
  wire       rref_sel = ctrl_reg[`DPRC_CTRL_RREF];

  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      ctrl_reg   <= `DPRC_CTRL_RST;
      ffgain_reg <= `DPRC_FFGAIN_RST;
      kp_reg     <= `DPRC_KP_RST;
      itime_reg  <= `DPRC_ITIME_RST;
      dtime_reg  <= `DPRC_DTIME_RST;
      limh_reg   <= `DPRC_LIMH_RST;
      liml_reg   <= `DPRC_LIML_RST;
      oscale_reg <= `DPRC_SCALE_RST;
      kp2_reg    <= `DPRC_SCALE_RST;
      pscale_reg <= `DPRC_SCALE_RST;
      chgovr_reg <= `DPRC_CHGOVR_RST;
      maxf_reg   <= `DPRC_MAXF_RST;
      tmap_reg   <= `DPRC_TMAP_RST;
      pair2_reg  <= {`DPRC_TIME_RST, `DPRC_TIME_RST};
      for (k = 0; k < 8; k = k + 1) begin
        step_mem[k] <= {`DPRC_TIME_RST, `DPRC_TIME_RST};
      end
    end else if (i_wr) begin
      case (i_addr)
        `DPRC_CTRL_OFS:   ctrl_reg   <= i_wdata[7:0];
        `DPRC_FFGAIN_OFS: ffgain_reg <= i_wdata[15:0];
        `DPRC_KP_OFS:     kp_reg     <= i_wdata[15:0];
        `DPRC_ITIME_OFS:  itime_reg  <= i_wdata[15:0];
        `DPRC_DTIME_OFS:  dtime_reg  <= i_wdata[15:0];
        `DPRC_LIMH_OFS:   limh_reg   <= i_wdata[15:0];
        `DPRC_LIML_OFS:   liml_reg   <= i_wdata[15:0];
        `DPRC_OSCALE_OFS: oscale_reg <= i_wdata[15:0];
        `DPRC_KP2_OFS:    kp2_reg    <= i_wdata[15:0];
        `DPRC_PSCALE_OFS: pscale_reg <= i_wdata[15:0];
        `DPRC_CHGOVR_OFS: chgovr_reg <= i_wdata[15:0];
        `DPRC_MAXF_OFS:   maxf_reg   <= i_wdata[15:0];
        `DPRC_TMAP_OFS:   tmap_reg   <= i_wdata[17:0];
        `DPRC_PAIR2_OFS:  pair2_reg  <= i_wdata;
        default: begin
          if (i_addr[7:5] == 3'h2) begin
            step_mem[i_addr[4:2]] <= i_wdata;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // read port
  // --------------------------------------------------------------------------
  always @* begin
    rdata_next = 32'h0000_0000;
    case (i_addr)
      `DPRC_CTRL_OFS:   rdata_next = {24'h000000, ctrl_reg};
      `DPRC_FFGAIN_OFS: rdata_next = {16'h0000, ffgain_reg};
      `DPRC_KP_OFS:     rdata_next = {16'h0000, kp_reg};
      `DPRC_ITIME_OFS:  rdata_next = {16'h0000, itime_reg};
      `DPRC_DTIME_OFS:  rdata_next = {16'h0000, dtime_reg};
      `DPRC_LIMH_OFS:   rdata_next = {16'h0000, limh_reg};
      `DPRC_LIML_OFS:   rdata_next = {16'h0000, liml_reg};
      `DPRC_OSCALE_OFS: rdata_next = {16'h0000, oscale_reg};
      `DPRC_KP2_OFS:    rdata_next = {16'h0000, kp2_reg};
      `DPRC_PSCALE_OFS: rdata_next = {16'h0000, pscale_reg};
      `DPRC_CHGOVR_OFS: rdata_next = {16'h0000, chgovr_reg};
      `DPRC_MAXF_OFS:   rdata_next = {16'h0000, maxf_reg};
      `DPRC_TMAP_OFS:   rdata_next = {14'h0000, tmap_reg};
      `DPRC_STFREQ_OFS: rdata_next = {15'h0000, o_closed_loop, o_freq_cmd};
      `DPRC_STPID_OFS:  rdata_next = {16'h0000, o_pid_out};
      `DPRC_PAIR2_OFS:  rdata_next = pair2_reg;
      default: begin
        if (i_addr[7:5] == 3'h2 && i_addr[1:0] == 2'h0) begin
          rdata_next = step_mem[i_addr[4:2]];
        end
      end
    endcase
  end

  // read data stand only in the cycle after the strobe
  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= i_rd ? rdata_next : 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------------
  // terminal synchronisers
  // --------------------------------------------------------------------------
  reg [5:0] term_s1;
  reg [5:0] term_s2;
  reg [5:0] term_s3;
  reg [5:0] term_reg;
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_term
      // only s2 and s3 are compared, s1 feeds s2 alone
      always @(posedge i_mclk) begin
        if (!i_rstn) begin
          term_s1[g]  <= 1'b0;
          term_s2[g]  <= 1'b0;
          term_s3[g]  <= 1'b0;
          term_reg[g] <= 1'b0;
        end else begin
          term_s1[g] <= i_programmable_terminals[g];
          term_s2[g] <= term_s1[g];
          term_s3[g] <= term_s2[g];
          if (term_s2[g] == term_s3[g]) begin
            term_reg[g] <= term_s3[g];
          end
        end
      end
    end
  endgenerate

  function func_on;
    input [2:0] idx;
    input [5:0] t;
    begin
      func_on = (idx < 3'h6) ? t[idx] : 1'b0;
    end
  endfunction

  wire bypass_on = func_on(tmap_reg[2:0], term_reg);
  wire iclr_on   = func_on(tmap_reg[5:3], term_reg);
  wire p2_on     = func_on(tmap_reg[8:6], term_reg);
  wire [2:0] xcel_bits = {func_on(tmap_reg[17:15], term_reg),
                          func_on(tmap_reg[14:12], term_reg),
                          func_on(tmap_reg[11:9], term_reg)};
  wire xcel_used = (tmap_reg[11:9] != `DPRC_FUNC_NONE) ||
                   (tmap_reg[14:12] != `DPRC_FUNC_NONE) ||
                   (tmap_reg[17:15] != `DPRC_FUNC_NONE);

  // --------------------------------------------------------------------------
  // control tick
  // --------------------------------------------------------------------------
  reg [31:0] tick_cnt_reg;
  reg        tick_reg;
  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == TICK_CYCLES - 1) begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      tick_reg     <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // regulator, 0.01 % units for error and output
  // --------------------------------------------------------------------------
  reg signed [47:0] acc_reg;
  reg signed [47:0] err_prev_reg;
  reg               sat_hi_reg;
  reg               sat_lo_reg;
  reg signed [47:0] ref_v, fb_v, err, kp_eff, p_t, i_t, d_t, ff_t, itk, ilim;
  reg signed [47:0] sum, outv, pid_hz, cmd, acc_next;
  reg               wind_up;
  localparam signed [47:0] FULL_PCT_W = `DPRC_FULL_PCT;

  always @* begin
    ref_v = (ctrl_reg[`DPRC_CTRL_AUX+0] && !1'b0) ?
            $signed({32'h0000_0000, i_aux_ref}) :
            $signed({32'h0000_0000, i_setpoint});
    case (fb_sel)
      2'h1:    fb_v = $signed({32'h0000_0000, i_voltage_feedback_one});
      2'h2:    fb_v = $signed({32'h0000_0000, i_voltage_feedback_two});
      default: fb_v = $signed({32'h0000_0000, i_fb_current});
    endcase
    err    = ref_v - fb_v;
    kp_eff = $signed({32'h0000_0000, p2_on ? kp2_reg : kp_reg}) *
             $signed({32'h0000_0000, pscale_reg}) / `DPRC_GAIN_ONE;
    p_t    = err * kp_eff / `DPRC_GAIN_ONE;
    itk    = $signed({32'h0000_0000, itime_reg}) *
             (`DPRC_ITIME_UNIT_US / `DPRC_TICK_US);
    ilim   = itk * `DPRC_FULL_PCT;
    i_t    = (itime_reg == 16'h0000) ? 48'sh0 : acc_reg / itk;
    d_t    = (err - err_prev_reg) * $signed({32'h0000_0000, dtime_reg}) *
             `DPRC_DTIME_UNIT_US / `DPRC_TICK_US;
    ff_t   = ref_v * $signed({32'h0000_0000, ffgain_reg}) / `DPRC_GAIN_ONE;
    sum    = p_t + i_t + d_t + ff_t;
    if (sum > FULL_PCT_W) begin
      sum = FULL_PCT_W;
    end else if (sum < -FULL_PCT_W) begin
      sum = -FULL_PCT_W;
    end
    outv = ctrl_reg[`DPRC_CTRL_NEG] ? -sum : sum;
    outv = outv * $signed({32'h0000_0000, oscale_reg}) / `DPRC_GAIN_ONE;
    // a disabled regulator reports zero too, so open loop reads idle from the next tick on
    if (bypass_on || !ctrl_reg[`DPRC_CTRL_EN]) begin
      outv = 48'sh0;
    end
    pid_hz = outv * $signed({32'h0000_0000, maxf_reg}) / `DPRC_FULL_PCT;
    cmd    = $signed({32'h0000_0000, i_target_freq}) + pid_hz;
    if (cmd > $signed({32'h0000_0000, limh_reg})) begin
      cmd = $signed({32'h0000_0000, limh_reg});
    end
    if (cmd < $signed({32'h0000_0000, liml_reg})) begin
      cmd = $signed({32'h0000_0000, liml_reg});
    end
    // hold the accumulator when pushing further into a saturated limit
    wind_up  = ((err > 0) ^ ctrl_reg[`DPRC_CTRL_NEG]) ? sat_hi_reg : sat_lo_reg;
    acc_next = acc_reg;
    if (err != 0 && !wind_up) begin
      acc_next = acc_reg + err;
    end
    if (acc_next > ilim) begin
      acc_next = ilim;
    end else if (acc_next < -ilim) begin
      acc_next = -ilim;
    end
  end

  wire closed = ctrl_reg[`DPRC_CTRL_EN] && !bypass_on;
  wire [15:0] ref_freq = closed ? cmd[15:0] : i_target_freq;

  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      acc_reg       <= 48'sh0;
      err_prev_reg  <= 48'sh0;
      sat_hi_reg    <= 1'b0;
      sat_lo_reg    <= 1'b0;
      o_pid_out     <= 16'h0000;
      o_closed_loop <= 1'b0;
    end else begin
      o_closed_loop <= closed;
      if (iclr_on || !closed) begin
        acc_reg <= 48'sh0;
      end else if (tick_reg) begin
        acc_reg <= acc_next;
      end
      if (tick_reg) begin
        err_prev_reg <= err;
        o_pid_out    <= outv[15:0];
        sat_hi_reg   <= closed && (cmd >= $signed({32'h0000_0000, limh_reg}));
        sat_lo_reg   <= closed && (cmd <= $signed({32'h0000_0000, liml_reg}));
      end
    end
  end

  // --------------------------------------------------------------------------
  // accel/decel ramp, frequency with 16 fraction bits
  // --------------------------------------------------------------------------
  reg [47:0] freq_acc_reg;
  reg [15:0] last_tgt_reg;
  reg [15:0] span_reg;
  reg [31:0] pair;
  reg [15:0] tsel;
  reg [47:0] tticks, span_w, step, nxt, tgt_f;
  wire [15:0] cur = freq_acc_reg[31:16];
  wire        up  = ref_freq > cur;

  always @* begin
    if (xcel_used) begin
      pair = step_mem[xcel_bits];
    end else if (chgovr_reg != 16'h0000 && cur >= chgovr_reg) begin
      pair = pair2_reg;
    end else begin
      pair = step_mem[0];
    end
    tsel = up ? pair[15:0] : pair[31:16];
    case (res_sel)
      2'h0:    tticks = {32'h0000_0000, tsel} * (`DPRC_RES0_US / `DPRC_TICK_US);
      2'h2:    tticks = {32'h0000_0000, tsel} * (`DPRC_RES2_US / `DPRC_TICK_US);
      default: tticks = {32'h0000_0000, tsel} * (`DPRC_RES1_US / `DPRC_TICK_US);
    endcase
    span_w = rref_sel ? {16'h0000, span_reg, 16'h0000} :
                        {16'h0000, maxf_reg, 16'h0000};
    step   = (tticks == 48'h0) ? {16'h0000, 16'hffff, 16'h0000} : span_w / tticks;
    if (step == 48'h0) begin
      step = 48'h1;
    end
    tgt_f = {16'h0000, ref_freq, 16'h0000};
    if (up) begin
      nxt = freq_acc_reg + step;
      if (nxt > tgt_f) begin
        nxt = tgt_f;
      end
    end else begin
      nxt = (freq_acc_reg > tgt_f + step) ? freq_acc_reg - step : tgt_f;
    end
  end

  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      freq_acc_reg <= 48'h0;
      last_tgt_reg <= 16'h0000;
      span_reg     <= 16'h0000;
      o_freq_cmd   <= 16'h0000;
    end else if (tick_reg) begin
      // delta mode measures the span once per new target
      if (ref_freq != last_tgt_reg) begin
        last_tgt_reg <= ref_freq;
        span_reg     <= up ? ref_freq - cur : cur - ref_freq;
      end
      freq_acc_reg <= nxt;
      o_freq_cmd   <= nxt[31:16];
    end
  end

endmodule // dprc_top

// File: tb/dprc_checker.sv
/*
 * port checker for the regulator and ramp block.
 * assumes one clock domain and a synchronous active-low reset.
 */
`timescale 1ns/10ps
module dprc_checker #(
  parameter TICK_CYCLES = 100000
) (
  input wire        i_mclk,
  input wire        i_rstn,
  input wire [7:0]  i_addr,
  input wire        i_wr,
  input wire        i_rd,
  input wire [31:0] o_rdata,
  input wire [15:0] o_freq_cmd,
  input wire [15:0] o_pid_out,
  input wire        o_closed_loop
);
  localparam int OPEN_LIM = 2 * TICK_CYCLES + 4;
  reg [31:0] gap_reg;
  reg [31:0] open_reg;
  // ---------------------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------------------
  // gap starts large so the first update after reset is allowed
  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      gap_reg  <= TICK_CYCLES;
      open_reg <= 32'h0;
    end else begin
      gap_reg  <= $changed(o_pid_out) ? 32'h0 : gap_reg + 32'h1;
      open_reg <= o_closed_loop ? 32'h0 : open_reg + 32'h1;
    end
  end
  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  property p_rd_idle; !$past(i_rd) |-> o_rdata == 32'h0; endproperty
  property p_wr_idle; i_wr |=> o_rdata == 32'h0; endproperty
  property p_rd_unmapped; i_rd && i_addr == 8'hfc |=> o_rdata == 32'h0; endproperty
  property p_rst_out;
    $rose(i_rstn) |-> o_freq_cmd == 16'h0 && o_pid_out == 16'h0 && !o_closed_loop;
  endproperty
  property p_pid_tick; $changed(o_pid_out) |-> gap_reg >= TICK_CYCLES - 1; endproperty
  property p_freq_hold; $changed(o_freq_cmd) |=> $stable(o_freq_cmd) [*8]; endproperty
  property p_open_zero;
    !o_closed_loop && open_reg > OPEN_LIM |-> o_pid_out == 16'h0;
  endproperty
  property p_open_fall;
    !o_closed_loop && open_reg == OPEN_LIM |-> o_pid_out == 16'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  a_wr_idle: assert property (p_wr_idle) else $error("read data after write");
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  a_rst_out: assert property (p_rst_out) else $error("outputs not clear after reset");
  a_pid_tick: assert property (p_pid_tick) else $error("pid out changed off tick");
  a_freq_hold: assert property (p_freq_hold) else $error("freq changed off tick");
  a_open_zero: assert property (p_open_zero) else $error("pid out not zero open");
  a_open_fall: assert property (p_open_fall) else $error("pid out kept on bypass");
  c_rise: cover property ($rose(o_closed_loop));
  c_fall: cover property ($fell(o_closed_loop));
  c_pid: cover property ($changed(o_pid_out));
  c_freq: cover property ($changed(o_freq_cmd));
endmodule // dprc_checker

bind dprc_top dprc_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .i_mclk       (i_mclk),
  .i_rstn       (i_rstn),
  .i_addr       (i_addr),
  .i_wr         (i_wr),
  .i_rd         (i_rd),
  .o_rdata      (o_rdata),
  .o_freq_cmd   (o_freq_cmd),
  .o_pid_out    (o_pid_out),
  .o_closed_loop(o_closed_loop)
);

// File: tb/dprc_plant.sv
/*
 * analog source model: setpoint and three feedback channels.
 * assumes the bench sets levels through set_levels after a clock edge.
 */
`timescale 1ns/10ps
module dprc_plant (
  input  wire        i_mclk,
  output reg  [15:0] o_setpoint,
  output reg  [15:0] o_aux_ref,
  output reg  [15:0] o_fb_current,
  output reg  [15:0] o_voltage_feedback_one,
  output reg  [15:0] o_voltage_feedback_two
);
  initial begin
    o_setpoint             = 16'h0;
    o_aux_ref              = 16'h5a5a;
    o_fb_current           = 16'h0;
    o_voltage_feedback_one = 16'h0;
    o_voltage_feedback_two = 16'h0;
  end
  // setpoint, current and voltage one feedback, each held level
  task set_levels(input [15:0] s, input [15:0] c, input [15:0] v);
    begin
      o_setpoint             <= s;
      o_fb_current           <= c;
      o_voltage_feedback_one <= v;
    end
  endtask
  // unselected channels never settle, so a wrong pick shows at once
  always @(posedge i_mclk) begin
    o_aux_ref              <= ~o_aux_ref;
    o_voltage_feedback_two <= o_voltage_feedback_two + 16'h1111;
  end
endmodule // dprc_plant

// File: tb/tb.sv
/*
 * self-checking bench for the regulator and ramp block.
 * assumes a short control tick of 20 clocks and the analog source model.
 */
`timescale 1ns/10ps
module tb;
  localparam TK = 20;
  reg         i_mclk, i_rstn, i_wr, i_rd, rd_d, smp;
  reg  [7:0]  i_addr;
  reg  [31:0] i_wdata, got;
  reg  [15:0] i_target_freq, rt;
  reg  [5:0]  i_programmable_terminals;
  reg  [2:0]  osel;
  reg  [31:0] rd_q[$];
  reg  [31:0] out_q[$];
  integer     seed, err_count, num_checks, i;
  wire [31:0] o_rdata;
  wire [15:0] o_freq_cmd, o_pid_out, sp, aux, fbc, fv1, fv2;
  wire        o_closed_loop;

  dprc_top #(.TICK_CYCLES(TK)) uut (
    .i_mclk                  (i_mclk),
    .i_rstn                  (i_rstn),
    .i_addr                  (i_addr),
    .i_wdata                 (i_wdata),
    .i_wr                    (i_wr),
    .i_rd                    (i_rd),
    .o_rdata                 (o_rdata),
    .i_setpoint              (sp),
    .i_aux_ref               (aux),
    .i_fb_current            (fbc),
    .i_voltage_feedback_one  (fv1),
    .i_voltage_feedback_two  (fv2),
    .i_target_freq           (i_target_freq),
    .i_programmable_terminals(i_programmable_terminals),
    .o_freq_cmd              (o_freq_cmd),
    .o_pid_out               (o_pid_out),
    .o_closed_loop           (o_closed_loop)
  );
  dprc_plant u_plant (
    .i_mclk                (i_mclk),
    .o_setpoint            (sp),
    .o_aux_ref             (aux),
    .o_fb_current          (fbc),
    .o_voltage_feedback_one(fv1),
    .o_voltage_feedback_two(fv2)
  );
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // ---------------------------------------------------------------------------
  // drivers and comparison
  // ---------------------------------------------------------------------------
  // strobes drop and a gap edge passes, so no signal is set twice at one edge
  task wr(input [7:0] a, input [31:0] d);
    begin
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      @(posedge i_mclk);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      rd_q.push_back(e);
      @(posedge i_mclk);
    end
  endtask
  task chk(input [2:0] s, input [31:0] e);
    begin
      out_q.push_back(e);
      osel <= s;
      smp  <= 1'b1;
      @(posedge i_mclk);
      smp <= 1'b0;
      @(posedge i_mclk);
    end
  endtask
  task ticks(input integer n);
    repeat (n * TK) @(posedge i_mclk);
  endtask
  task step(input [7:0] a, input [31:0] d, input [15:0] t, input [2:0] s, input [31:0] e);
    begin
      wr(a, d);
      i_target_freq <= t;
      ticks(3);
      chk(s, e);
    end
  endtask
  // ramp from zero towards 3000 with first pair 10 units, sampled after w ticks
  task ramp(input [7:0] c, input [15:0] cg, input [31:0] tm, input integer w, input [31:0] e);
    begin
      wr(8'h28, {16'h0, cg});
      wr(8'h30, tm);
      wr(8'h40, 32'h0);
      i_target_freq <= 16'h0;
      ticks(2);
      wr(8'h40, 32'h000a000a);
      wr(8'h00, {24'h0, c});
      i_target_freq <= 16'd3000;
      ticks(w);
      chk(3'd3, e);
    end
  endtask
  task report(input [31:0] g, input [31:0] e);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task cmp_rd(input [31:0] e);
    report(o_rdata, e);
  endtask
  task cmp_out(input [31:0] e);
    begin
      case (osel)
        3'd0: got = {16'h0, o_freq_cmd};
        3'd1: got = {16'h0, o_pid_out};
        3'd2: got = {31'h0, o_closed_loop};
        3'd3: got = {31'h0, o_freq_cmd === 16'd3000};
        default: got = {31'h0, o_pid_out !== 16'h0};
      endcase
      report(got, e);
    end
  endtask
  always @(posedge i_mclk) begin
    rd_d <= i_rd;
    if (rd_d) cmp_rd(rd_q.pop_front());
    if (smp) cmp_out(out_q.pop_front());
  end
  task finish_test;
    begin
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // run is about 8100 cycles; nearly four times that means a hang
  initial begin
    repeat (30000) @(posedge i_mclk);
    err_count = err_count + 1;
    finish_test;
  end
  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    seed = 32'h45a5af56;
    err_count = 0;
    num_checks = 0;
    {i_rstn, i_wr, i_rd, smp, osel, i_addr, i_wdata} = 0;
    i_target_freq = 16'h0;
    i_programmable_terminals = 6'h0;
    repeat (20) @(posedge i_mclk);
    i_rstn <= 1'b1;
    rd(8'h00, 32'h40);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0a);
    rd(8'h0c, 32'h64);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h1770);
    rd(8'h18, 32'h0);
    rd(8'h1c, 32'h3e8);
    rd(8'h20, 32'h3e8);
    rd(8'h24, 32'h3e8);
    rd(8'h28, 32'h0);
    rd(8'h40, 32'h00320032);
    wr(8'hfc, 32'h5a);
    rd(8'hfc, 32'h0);
    // bypass: random manual command passes straight through
    u_plant.set_levels(16'd5000, 16'h0, 16'd2000);
    wr(8'h40, 32'h0);
    wr(8'h0c, 32'h0);
    wr(8'h30, 32'h3fff8);
    wr(8'h00, 32'h41);
    i_programmable_terminals <= 6'h01;
    for (i = 0; i < 3; i = i + 1) begin
      rt = {$random(seed)} % 32'd6000;
      i_target_freq <= rt;
      ticks(3);
      chk(3'd0, {16'h0, rt});
      chk(3'd1, 32'h0);
      chk(3'd2, 32'h0);
    end
    i_programmable_terminals <= 6'h02;
    step(8'h08, 32'd1000, 16'h0, 3'd2, 32'h1);
    step(8'h08, 32'd1000, 16'h0, 3'd1, 32'd5000);
    step(8'h08, 32'd1000, 16'h0, 3'd0, 32'd3000);
    step(8'h24, 32'd500, 16'h0, 3'd1, 32'd2500);
    step(8'h20, 32'd200, 16'h0, 3'd1, 32'd2500);
    step(8'h30, 32'h3fe78, 16'h0, 3'd1, 32'd500);
    step(8'h1c, 32'd500, 16'h0, 3'd1, 32'd250);
    step(8'h00, 32'h43, 16'h0, 3'd1, 32'd150);
    step(8'h00, 32'h4b, 16'h0, 3'd1, 32'hff6a);
    step(8'h18, 32'd2000, 16'd1000, 3'd0, 32'd2000);
    step(8'h14, 32'd3000, 16'd5000, 3'd0, 32'd3000);
    step(8'h04, 32'd1000, 16'd5000, 3'd1, 32'hf5a6);
    wr(8'h04, 32'h0);
    // integral alone, then cleared from its terminal
    i_programmable_terminals <= 6'h00;
    wr(8'h08, 32'h0);
    wr(8'h0c, 32'h1);
    step(8'h30, 32'h3fe50, 16'd2500, 3'd4, 32'h1);
    i_programmable_terminals <= 6'h04;
    ticks(2);
    chk(3'd1, 32'h0);
    // open loop ramps: resolution, reference, change-over, step priority
    i_programmable_terminals <= 6'h01;
    wr(8'h3c, 32'h0);
    ramp(8'h00, 16'h0, 32'h3fff8, 58, 32'h1);
    ramp(8'h00, 16'h0, 32'h3fff8, 38, 32'h0);
    ramp(8'h20, 16'h0, 32'h3fff8, 58, 32'h0);
    ramp(8'h40, 16'h0, 32'h3fff8, 58, 32'h0);
    ramp(8'h80, 16'h0, 32'h3fff8, 58, 32'h0);
    ramp(8'h00, 16'd1000, 32'h3fff8, 30, 32'h1);
    ramp(8'h00, 16'd1000, 32'h3f7f8, 30, 32'h0);
    repeat (4) @(posedge i_mclk);
    finish_test;
  end
endmodule // tb
